/* File: hdl/ddl_loader.sv */
// dual dac serial loader: shift word in, transfer latches on frame end
`timescale 1ns/100ps
`default_nettype none
module ddl_loader
    import ddl_pkg::*;
#(
    parameter logic COUNTING = 1'b1
)
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  ce,
    input  wire logic                  cs_n,
    input  wire logic                  sclk,
    input  wire logic                  sdin,
    output var  logic [DDL_CODE_W-1:0] dac_a_code,
    output var  logic [DDL_CODE_W-1:0] dac_b_code,
    output var  logic                  fast_mode,
    output var  logic                  power_down,
    output var  logic                  update_pulse
);
    ////////////////////////////////////////////////////////////////////////
    logic cs_s;
    logic sclk_s;
    logic sdin_s;
    logic cs_d_r;
    logic sclk_d_r;
    ddl_state_t st_r;
    logic [DDL_WORD_W-1:0] sir_r;
    logic [DDL_CNT_W-1:0]  cnt_r;
    ddl_latch_t lat_r;

    // select idles high; a high reset value avoids a false frame start
    ddl_sync #(.RST_VAL(1'b1)) u_cs
    (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d      (cs_n),
        .q      (cs_s)
    );

    ddl_sync #(.RST_VAL(1'b0)) u_sclk
    (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d      (sclk),
        .q      (sclk_s)
    );

    // same depth as the clock path, so data lines up with its edge
    ddl_sync #(.RST_VAL(1'b0)) u_sdin
    (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d      (sdin),
        .q      (sdin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // sampled clock sees edges only; sclk must be well below clk/4
    wire       cs_fall   = cs_d_r & ~cs_s;
    wire       cs_rise   = ~cs_d_r & cs_s;
    wire       sclk_fall = sclk_d_r & ~sclk_s;
    wire       count_end = COUNTING && (cnt_r == DDL_FRAME_BITS);
    wire       shifting  = (st_r == DDL_SHIFT) && !cs_s;
    wire       do_shift  = shifting && sclk_fall && !count_end;
    // frame end ORed with select: whichever comes first transfers once
    wire       frame_end = (st_r == DDL_SHIFT) && (cs_rise || count_end);
    ddl_word_t wrd;
    assign     wrd       = ddl_word_t'(sir_r);

    // three transfer kinds; exactly one applies per frame
    wire       load_a    = wrd.latch_select_bit;
    wire       load_both = !wrd.latch_select_bit && !wrd.buffer_only_bit;
    wire       load_buf  = !wrd.latch_select_bit && wrd.buffer_only_bit;

    ddl_latch_t lat_nxt;
    assign lat_nxt.latch_a = load_a ? wrd.code : lat_r.latch_a;
    // b only differs from the buffer after a buffer-only write
    assign lat_nxt.latch_b = load_a    ? lat_r.dbl_buf :
                             load_both ? wrd.code : lat_r.latch_b;
    assign lat_nxt.dbl_buf = (load_both || load_buf) ? wrd.code : lat_r.dbl_buf;

    ////////////////////////////////////////////////////////////////////////
    // next values; the registers below only load them
    ddl_state_t            st_nxt;
    logic [DDL_WORD_W-1:0] sir_nxt;
    logic [DDL_CNT_W-1:0]  cnt_nxt;
    logic                  fast_nxt;
    logic                  pwr_nxt;

    assign sir_nxt  = do_shift ? {sir_r[DDL_WORD_W-2:0], sdin_s} : sir_r;
    // select fall restarts the count, so a cut frame's bit count never carries into the next
    assign cnt_nxt  = cs_fall  ? '0 :
                      do_shift ? cnt_r + 5'h01 : cnt_r;
    assign fast_nxt = frame_end ? wrd.speed_bit : fast_mode;
    assign pwr_nxt  = frame_end ? wrd.power_down_bit : power_down;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            DDL_IDLE:
                if (cs_fall)
                    st_nxt = DDL_SHIFT;
            DDL_SHIFT:
                if (frame_end)
                    st_nxt = DDL_IDLE;
            default:
                st_nxt = DDL_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // edge history of the synchronised select and shift clock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cs_d_r <= 1'b1;
        end
        else if (ce)
        begin
            cs_d_r <= cs_s;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_d_r <= 1'b0;
        end
        else if (ce)
        begin
            sclk_d_r <= sclk_s;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= DDL_IDLE;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // not cleared per frame: a short frame shifts old bits up
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sir_r <= DDL_WORD_RST;
        end
        else if (ce)
        begin
            sir_r <= sir_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // latches move only on a frame end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lat_r <= '0;
        end
        else if (ce && frame_end)
        begin
            lat_r <= lat_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_mode <= 1'b0;
        end
        else if (ce)
        begin
            fast_mode <= fast_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_down <= 1'b0;
        end
        else if (ce)
        begin
            power_down <= pwr_nxt;
        end
    end

    // same edge as the latches, so it marks the cycle they change
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            update_pulse <= 1'b0;
        end
        else if (ce)
        begin
            update_pulse <= frame_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign dac_a_code = lat_r.latch_a;
    assign dac_b_code = lat_r.latch_b;
endmodule
`default_nettype wire

/* File: hdl/ddl_sync.sv */
// two-flop synchroniser for one pin input
`timescale 1ns/100ps
`default_nettype none
module ddl_sync
    import ddl_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic d,
    output var  logic q
);
    logic meta_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else if (ce)
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: shared/ddl_pkg.sv */
// package: constants, types and word layout of the dual dac serial loader
package ddl_pkg;
    localparam int          DDL_WORD_W      = 16;
    localparam int          DDL_CODE_W      = 12;
    localparam int          DDL_CNT_W       = 5;
    localparam logic [4:0]  DDL_FRAME_BITS  = 5'h10;
    localparam int          DDL_LATCH_SEL   = 15;
    localparam int          DDL_SPEED       = 14;
    localparam int          DDL_PWR_DN      = 13;
    localparam int          DDL_BUF_ONLY    = 12;
    localparam logic [11:0] DDL_CODE_RST    = 12'h000;
    localparam logic [15:0] DDL_WORD_RST    = 16'h0000;
    localparam real         DDL_SLOW_SETTLE_US = 12.5;
    localparam real         DDL_FAST_SETTLE_US = 2.5;

    typedef struct packed {
        logic latch_select_bit;
        logic speed_bit;
        logic power_down_bit;
        logic buffer_only_bit;
        logic [DDL_CODE_W-1:0] code;
    } ddl_word_t;

    typedef struct packed {
        logic [DDL_CODE_W-1:0] latch_a;
        logic [DDL_CODE_W-1:0] latch_b;
        logic [DDL_CODE_W-1:0] dbl_buf;
    } ddl_latch_t;

    typedef enum logic {DDL_IDLE, DDL_SHIFT} ddl_state_t;
endpackage

/* File: sim/ddl_host_model.sv */
// host model: select, shift clock and data of the serial link
`timescale 1ns/100ps
`default_nettype none
module ddl_host_model
(
    output var logic cs_n,
    output var logic sclk,
    output var logic sdin
);
    initial {cs_n, sclk, sdin} = 3'b110;
    // 32 ns link period; sclk parked high outside frames
    task automatic send(input logic [19:0] v, input int nb);
        cs_n = 1'b0;
        #20;
        for (int i = nb - 1; i >= 0; i--)
        begin
            sdin = v[i];
            #16 sclk = 1'b0;
            #16 sclk = 1'b1;
            if (i == nb - 8)
                #40;
        end
        cs_n = 1'b1;
        sdin = ~sdin;
        #40;
    endtask
endmodule
`default_nettype wire

/* File: sim/ddl_loader_properties.sv */
// checker: port timing of the dual dac serial loader
`timescale 1ns/100ps
`default_nettype none
module ddl_loader_properties
    import ddl_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic                  cs_n,
    input wire logic [DDL_CODE_W-1:0] dac_a_code,
    input wire logic [DDL_CODE_W-1:0] dac_b_code,
    input wire logic                  fast_mode,
    input wire logic                  power_down,
    input wire logic                  update_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_reset_clear: assert property ($rose(arst_n) |-> dac_a_code == 12'h000 && dac_b_code == 12'h000)
        else $error("latch not clear");
    chk_a_hold: assert property ($changed(dac_a_code) |-> update_pulse)
        else $error("latch a moved");
    chk_b_hold: assert property ($changed(dac_b_code) |-> update_pulse)
        else $error("latch b moved");
    chk_fast_hold: assert property ($changed(fast_mode) |-> update_pulse)
        else $error("speed moved");
    chk_pwr_hold: assert property ($changed(power_down) |-> update_pulse)
        else $error("power moved");
    chk_one_transfer: assert property (update_pulse |=> !update_pulse [*8])
        else $error("second transfer");
    chk_idle_quiet: assert property (cs_n [*8] |-> !update_pulse)
        else $error("idle transfer");
    chk_no_early: assert property (cs_n ##1 !cs_n |-> !update_pulse [*8])
        else $error("early transfer");
endmodule
`default_nettype wire

/* File: sim/ddl_loader_tb.sv */
// testbench: host frames against the latch transfer behaviour
`timescale 1ns/100ps
`default_nettype none
module ddl_loader_tb
    import ddl_pkg::*;
;
    logic                  clk;
    logic                  arst_n;
    logic                  ce;
    logic                  cs_n;
    logic                  sclk;
    logic                  sdin;
    logic [DDL_CODE_W-1:0] dac_a_code;
    logic [DDL_CODE_W-1:0] dac_b_code;
    logic                  fast_mode;
    logic                  power_down;
    logic                  update_pulse;
    logic [DDL_CODE_W-1:0] ea = '0, eb = '0, ed = '0;
    int                    errors = 0, n_tests = 0, n_upd = 0, cyc = 0;
    ddl_host_model host (.cs_n(cs_n), .sclk(sclk), .sdin(sdin));
    ddl_loader dut (.clk(clk), .arst_n(arst_n), .ce(ce), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .fast_mode(fast_mode),
        .power_down(power_down), .update_pulse(update_pulse));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk)
    begin
        n_upd += int'(update_pulse === 1'b1);
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic xfer(input ddl_word_t w, input int nb);
        int n0;
        n0 = n_upd;
        host.send(nb == 20 ? {w, 4'hF} : {4'h0, w}, nb);
        if (w.latch_select_bit)
        begin
            ea = w.code;
            eb = ed;
        end
        else
            ed = w.code;
        if (!w.latch_select_bit && !w.buffer_only_bit)
            eb = w.code;
        chk(12'(n_upd - n0), 12'h001);
        chk(dac_a_code, ea);
        chk(dac_b_code, eb);
        chk(12'(fast_mode), 12'(w.speed_bit));
        chk(12'(power_down), 12'(w.power_down_bit));
    endtask
    task t_reset;
        chk(dac_a_code, DDL_CODE_RST);
        chk(dac_b_code, DDL_CODE_RST);
    endtask
    task t_latch_b;
        xfer(16'h0ABC, 16);
    endtask
    task t_both;
        xfer(16'h1123, 16);
        xfer(16'h8800, 16);
    endtask
    task t_extra_clocks;
        xfer(16'hE555, 20);
        xfer(16'h4FFF, 16);
        // 12 bits: low nibble of the last word moves up to the top
        xfer(16'hF123, 12);
    endtask
    task automatic t_ce_freeze;
        int n0;
        n0 = n_upd;
        ce = 1'b0;
        host.send(20'h08FFF, 16);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        chk(12'(n_upd - n0), 12'h000);
        chk(dac_a_code, ea);
        chk(dac_b_code, eb);
    endtask
    initial
    begin
        arst_n = 1'b0;
        ce     = 1'b1;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_latch_b();
        t_both();
        t_extra_clocks();
        t_ce_freeze();
        final_report();
    end
endmodule
bind ddl_loader ddl_loader_properties chk_i (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code), .fast_mode(fast_mode), .power_down(power_down), .update_pulse(update_pulse));
`default_nettype wire
